// File: rtl/oqf_packer.v
// object quality frame packer: fifo plus framer with ahb-lite registers
// assumes one object record per handshake from the scheduler, in the same
// order as the general object frames; frame port drains into a can core
//
// Contract
// [R01] frames 0x60C go out only while the quality output enable is set; code applies it at the next cycle_start, queued frames still drain
// [R02] one frame per tracked object, same order as general object frames
// [R03] 8-bit object number placed at bit 0, passed unchanged
// [R04] longitudinal distance deviation code, 5 bits, at bit 11
// [R05] longitudinal velocity deviation code, 5 bits, at bit 17
// [R06] lateral distance deviation code, 5 bits, at bit 22
// [R07] lateral velocity deviation code, 5 bits, at bit 28
// [R08] lateral acceleration deviation code, 5 bits, at bit 34
// [R09] longitudinal acceleration deviation code, 5 bits, at bit 39
// [R10] orientation deviation code in degrees, 5 bits, at bit 45
// [R11] 3-bit lifecycle code at bit 50, values 0 to 5 defined
// [R12] code 0 marks a deleted object in its final cycles
// [R13] code 1 marks a new object in its first cycles
// [R14] code 2 measured with cluster, code 3 predicted without cluster
// [R15] code 4 deleted for merge, code 5 new from merge
// [R16] 3-bit existence likelihood code at bit 53
// [R17] deviation codes map to nonlinear upper bounds via lookup table
// [R18] eight-byte payload, undefined bits driven to zero
// [R19] host pairs quality and general frames by object number per cycle
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "oqf_defines.vh"

module oqf_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = `OQF_FIFO_DEPTH,
	parameter AW = `OQF_FIFO_AW
) (
	input wire hclk,
	input wire hresetn,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];
	assign level = count;

	always @(posedge hclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module oqf_packer #(
	parameter DEPTH = `OQF_FIFO_DEPTH,
	parameter AW = `OQF_FIFO_AW
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire cycle_start,
	input wire obj_valid,
	output wire obj_ready,
	input wire [7:0] tracked_object_number,
	input wire [4:0] long_distance_deviation_code,
	input wire [4:0] long_velocity_deviation_code,
	input wire [4:0] lat_distance_deviation_code,
	input wire [4:0] lat_velocity_deviation_code,
	input wire [4:0] lat_accel_deviation_code,
	input wire [4:0] long_accel_deviation_code,
	input wire [4:0] orient_deviation_code,
	input wire [2:0] track_lifecycle_code,
	input wire [2:0] existence_likelihood_code,
	output wire frame_valid,
	input wire frame_ready,
	output wire [10:0] frame_id,
	output wire [3:0] frame_dlc,
	output wire [63:0] frame_data
);
	reg quality_output_enable;
	reg cycle_enable;
	reg [31:0] sent_count;
	reg [31:0] drop_count;
	reg [15:0] cycle_counter;
	reg [31:0] life_err_count;
	reg [4:0] lut_sel;
	reg dp_write;
	reg [7:0] dp_addr;
	reg [63:0] payload;
	wire fifo_in_ready;
	wire [AW:0] fifo_level;
	wire addr_phase;
	wire obj_take;
	wire [35:0] lut_pair;
	reg [31:0] next_rdata;

	// upper bounds in thousandths: {orientation deg, linear quantity}
	function [35:0] dev_bound;
		input [4:0] code;
		begin
			case (code) // [R17]
			5'h00: dev_bound = {18'd5, 18'd5};
			5'h01: dev_bound = {18'd7, 18'd6};
			5'h02: dev_bound = {18'd10, 18'd8};
			5'h03: dev_bound = {18'd14, 18'd11};
			5'h04: dev_bound = {18'd20, 18'd14};
			5'h05: dev_bound = {18'd29, 18'd18};
			5'h06: dev_bound = {18'd41, 18'd23};
			5'h07: dev_bound = {18'd58, 18'd29};
			5'h08: dev_bound = {18'd82, 18'd38};
			5'h09: dev_bound = {18'd116, 18'd49};
			5'h0A: dev_bound = {18'd165, 18'd63};
			5'h0B: dev_bound = {18'd234, 18'd81};
			5'h0C: dev_bound = {18'd332, 18'd105};
			5'h0D: dev_bound = {18'd471, 18'd135};
			5'h0E: dev_bound = {18'd669, 18'd174};
			5'h0F: dev_bound = {18'd949, 18'd224};
			5'h10: dev_bound = {18'd1346, 18'd288};
			5'h11: dev_bound = {18'd1909, 18'd371};
			5'h12: dev_bound = {18'd2709, 18'd478};
			5'h13: dev_bound = {18'd3843, 18'd616};
			5'h14: dev_bound = {18'd5451, 18'd794};
			5'h15: dev_bound = {18'd7734, 18'd1023};
			5'h16: dev_bound = {18'd10971, 18'd1317};
			5'h17: dev_bound = {18'd15565, 18'd1697};
			5'h18: dev_bound = {18'd22081, 18'd2187};
			5'h19: dev_bound = {18'd31325, 18'd2817};
			5'h1A: dev_bound = {18'd44439, 18'd3630};
			5'h1B: dev_bound = {18'd63044, 18'd4676};
			5'h1C: dev_bound = {18'd89437, 18'd6025};
			5'h1D: dev_bound = {18'd126881, 18'd7762};
			5'h1E: dev_bound = {18'd180000, 18'd10000};
			default: dev_bound = {`OQF_LUT_INVALID, `OQF_LUT_INVALID};
			endcase
		end
	endfunction

	// payload assembly; every unassigned bit stays zero
	always @* begin
		payload = 64'h0000000000000000; // [R18]
		payload[`OQF_POS_OBJ +: 8] = tracked_object_number; // [R03]
		payload[`OQF_POS_LONG_DIST +: `OQF_W_DEV] =
			long_distance_deviation_code; // [R04]
		payload[`OQF_POS_LONG_VEL +: `OQF_W_DEV] =
			long_velocity_deviation_code; // [R05]
		payload[`OQF_POS_LAT_DIST +: `OQF_W_DEV] =
			lat_distance_deviation_code; // [R06]
		payload[`OQF_POS_LAT_VEL +: `OQF_W_DEV] =
			lat_velocity_deviation_code; // [R07]
		payload[`OQF_POS_LAT_ACC +: `OQF_W_DEV] =
			lat_accel_deviation_code; // [R08]
		payload[`OQF_POS_LONG_ACC +: `OQF_W_DEV] =
			long_accel_deviation_code; // [R09]
		payload[`OQF_POS_ORIENT +: `OQF_W_DEV] =
			orient_deviation_code; // [R10]
		payload[`OQF_POS_LIFE +: `OQF_W_CODE] =
			track_lifecycle_code; // [R11] [R12] [R13] [R14] [R15]
		payload[`OQF_POS_EXIST +: `OQF_W_CODE] =
			existence_likelihood_code; // [R16]
	end

	// disabled: records are consumed and dropped so the scheduler never stalls
	assign obj_ready = cycle_enable ? fifo_in_ready : 1'b1; // [R01]
	assign obj_take = obj_valid && obj_ready;

	// fifo keeps object order across the frame port [R02]
	oqf_fifo #(
		.WIDTH(64),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(obj_valid && cycle_enable), // [R01]
		.in_ready(fifo_in_ready),
		.in_data(payload),
		.out_valid(frame_valid),
		.out_ready(frame_ready),
		.out_data(frame_data),
		.level(fifo_level)
	);

	assign frame_id = `OQF_FRAME_ID;
	assign frame_dlc = `OQF_FRAME_DLC; // [R18]

	// ahb-lite slave, zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;
	assign lut_pair = dev_bound(lut_sel); // [R17]

	always @* begin
		next_rdata = 32'h00000000;
		case (haddr[7:0])
		`OQF_REG_CTRL: begin
			next_rdata[`OQF_CTRL_ENABLE] = quality_output_enable;
		end
		`OQF_REG_STATUS: begin
			next_rdata[AW:0] = fifo_level;
			next_rdata[`OQF_STAT_EMPTY] = !frame_valid;
			next_rdata[`OQF_STAT_FULL] = !fifo_in_ready;
			next_rdata[`OQF_STAT_ACTIVE] = cycle_enable;
		end
		`OQF_REG_SENT: next_rdata = sent_count;
		`OQF_REG_DROP: next_rdata = drop_count;
		`OQF_REG_CYCLE: next_rdata[15:0] = cycle_counter;
		`OQF_REG_LUT_SEL: next_rdata[4:0] = lut_sel;
		`OQF_REG_LUT_ORIENT: next_rdata[17:0] = lut_pair[35:18];
		`OQF_REG_LUT_LIN: next_rdata[17:0] = lut_pair[17:0];
		`OQF_REG_LIFE_ERR: next_rdata = life_err_count;
		default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			dp_write <= addr_phase && hwrite;
			dp_addr <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	// software state and counters; hardware increments win over clears
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quality_output_enable <= `OQF_CTRL_RESET;
			cycle_enable <= 1'b0;
			cycle_counter <= 16'h0000;
			sent_count <= 32'h00000000;
			drop_count <= 32'h00000000;
			life_err_count <= 32'h00000000;
			lut_sel <= 5'h00;
		end else begin
			if (dp_write && dp_addr == `OQF_REG_CTRL) begin
				quality_output_enable <= hwdata[`OQF_CTRL_ENABLE];
			end
			if (dp_write && dp_addr == `OQF_REG_LUT_SEL) begin
				lut_sel <= hwdata[4:0];
			end
			// enable takes effect at a cycle boundary so a cycle is whole
			if (cycle_start) begin
				cycle_enable <= quality_output_enable; // [R01] [R02]
				cycle_counter <= cycle_counter + 16'h0001;
			end
			if (obj_take && cycle_enable) begin
				sent_count <= sent_count + 32'h00000001;
			end else if (dp_write && dp_addr == `OQF_REG_SENT) begin
				sent_count <= 32'h00000000;
			end
			if (obj_take && !cycle_enable) begin
				drop_count <= drop_count + 32'h00000001;
			end else if (dp_write && dp_addr == `OQF_REG_DROP) begin
				drop_count <= 32'h00000000;
			end
			// lifecycle codes 6 and 7 are undefined: counted, sent as given
			if (obj_take && cycle_enable &&
				track_lifecycle_code > `OQF_LIFE_NEW_MERGE) begin // [R11]
				life_err_count <= life_err_count + 32'h00000001;
			end else if (dp_write && dp_addr == `OQF_REG_LIFE_ERR) begin
				life_err_count <= 32'h00000000;
			end
		end
	end
endmodule

// File: shared/oqf_defines.vh
// constants for the object quality frame packer
// assumes inclusion by bare name from rtl files
`ifndef OQF_DEFINES_VH
`define OQF_DEFINES_VH

`define OQF_FRAME_ID 11'h60C
`define OQF_FRAME_DLC 4'h8
`define OQF_FIFO_DEPTH 32
`define OQF_FIFO_AW 5

// payload field start positions and widths
`define OQF_POS_OBJ 0
`define OQF_POS_LONG_DIST 11
`define OQF_POS_LONG_VEL 17
`define OQF_POS_LAT_DIST 22
`define OQF_POS_LAT_VEL 28
`define OQF_POS_LAT_ACC 34
`define OQF_POS_LONG_ACC 39
`define OQF_POS_ORIENT 45
`define OQF_POS_LIFE 50
`define OQF_POS_EXIST 53
`define OQF_W_DEV 5
`define OQF_W_CODE 3

// lifecycle codes
`define OQF_LIFE_DELETED 3'h0
`define OQF_LIFE_NEW 3'h1
`define OQF_LIFE_MEASURED 3'h2
`define OQF_LIFE_PREDICTED 3'h3
`define OQF_LIFE_DEL_MERGE 3'h4
`define OQF_LIFE_NEW_MERGE 3'h5

// register byte offsets
`define OQF_REG_CTRL 8'h00
`define OQF_REG_STATUS 8'h04
`define OQF_REG_SENT 8'h08
`define OQF_REG_DROP 8'h0C
`define OQF_REG_CYCLE 8'h10
`define OQF_REG_LUT_SEL 8'h14
`define OQF_REG_LUT_ORIENT 8'h18
`define OQF_REG_LUT_LIN 8'h1C
`define OQF_REG_LIFE_ERR 8'h20

// register fields and reset values
`define OQF_CTRL_ENABLE 0
`define OQF_CTRL_RESET 1'b0
`define OQF_STAT_EMPTY 8
`define OQF_STAT_FULL 9
`define OQF_STAT_ACTIVE 10
`define OQF_LUT_INVALID 18'h3FFFF

`endif

// File: verification/oqf_host_model.sv
// host side frame sink, prompt, slow or stalled
// assumes the frame port of oqf_packer
`timescale 1ns/1ps
module oqf_host_model (
	input wire hclk,
	input wire hresetn,
	input wire stall,
	input wire slow,
	output reg frame_ready
);
	reg tick;
	// takes frames in order; pairing by object number is left to software
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick <= 1'b0;
			frame_ready <= 1'b0;
		end else begin
			tick <= ~tick;
			frame_ready <= !stall && !(slow && tick);
		end
	end
endmodule

// File: verification/oqf_packer_assertions.sv
// port checker for the object quality frame packer
// assumes binding onto every oqf_packer instance
`timescale 1ns/1ps
module oqf_checker (
	input wire hclk,
	input wire hresetn,
	input wire obj_valid,
	input wire obj_ready,
	input wire [7:0] tracked_object_number,
	input wire [4:0] long_distance_deviation_code,
	input wire [4:0] long_velocity_deviation_code,
	input wire [4:0] lat_distance_deviation_code,
	input wire [4:0] lat_velocity_deviation_code,
	input wire [4:0] lat_accel_deviation_code,
	input wire [4:0] long_accel_deviation_code,
	input wire [4:0] orient_deviation_code,
	input wire [2:0] track_lifecycle_code,
	input wire [2:0] existence_likelihood_code,
	input wire frame_valid,
	input wire frame_ready,
	input wire [10:0] frame_id,
	input wire [3:0] frame_dlc,
	input wire [63:0] frame_data
);
	wire [63:0] p = {8'h00, existence_likelihood_code, track_lifecycle_code,
		orient_deviation_code, 1'b0, long_accel_deviation_code,
		lat_accel_deviation_code, 1'b0, lat_velocity_deviation_code, 1'b0,
		lat_distance_deviation_code, long_velocity_deviation_code, 1'b0,
		long_distance_deviation_code, 3'h0, tracked_object_number};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence push_empty;
		obj_valid && obj_ready && !frame_valid;
	endsequence
	sequence first_out;
		push_empty ##1 frame_valid;
	endsequence
	a_frame_id: assert property (frame_id == 11'h60C)
		else $error("frame id wrong");
	a_dlc_eight: assert property (frame_dlc == 4'h8)
		else $error("frame length wrong");
	a_pad_zero: assert property (frame_valid |->
		(frame_data & 64'hFF00_1002_0801_0700) == 64'h0)
		else $error("unused payload bit set");
	a_frame_hold: assert property (frame_valid && !frame_ready |=>
		frame_valid && $stable(frame_data)) else $error("frame dropped");
	a_rise_push: assert property ($rose(frame_valid) |->
		$past(obj_valid && obj_ready)) else $error("frame without object");
	a_ready_empty: assert property (!frame_valid |-> obj_ready)
		else $error("refused while empty");
	a_obj_number: assert property (first_out |->
		frame_data[7:0] == $past(p[7:0])) else $error("object number wrong");
	a_deviation_codes: assert property (first_out |->
		frame_data[49:11] == $past(p[49:11])) else $error("deviation wrong");
	a_state_codes: assert property (first_out |->
		frame_data[55:50] == $past(p[55:50])) else $error("state code wrong");
endmodule
bind oqf_packer oqf_checker chk_u (.hclk(hclk), .hresetn(hresetn),
	.obj_valid(obj_valid), .obj_ready(obj_ready),
	.tracked_object_number(tracked_object_number),
	.long_distance_deviation_code(long_distance_deviation_code),
	.long_velocity_deviation_code(long_velocity_deviation_code),
	.lat_distance_deviation_code(lat_distance_deviation_code),
	.lat_velocity_deviation_code(lat_velocity_deviation_code),
	.lat_accel_deviation_code(lat_accel_deviation_code),
	.long_accel_deviation_code(long_accel_deviation_code),
	.orient_deviation_code(orient_deviation_code),
	.track_lifecycle_code(track_lifecycle_code),
	.existence_likelihood_code(existence_likelihood_code),
	.frame_valid(frame_valid), .frame_ready(frame_ready),
	.frame_id(frame_id), .frame_dlc(frame_dlc), .frame_data(frame_data));

// File: verification/tb.sv
// self-checking bench for the quality frame packer
// assumes oqf_packer, oqf_host_model and the bound checker
`timescale 1ns/1ps
`include "oqf_defines.vh"
module tb;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg cycle_start = 1'b0;
	reg obj_valid = 1'b0;
	reg [63:0] rec = 64'h0;
	reg stall = 1'b0;
	reg slow = 1'b0;
	reg [31:0] d;
	wire [31:0] hrdata;
	wire hreadyout;
	wire obj_ready;
	wire frame_valid;
	wire frame_ready;
	wire [63:0] frame_data;
	wire hresp;
	wire [10:0] frame_id;
	wire [3:0] frame_dlc;
	logic [63:0] rx[$];
	integer mismatches = 0;
	integer checked = 0;
	integer i;
	always #50 hclk = ~hclk;
	oqf_packer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cycle_start(cycle_start),
		.obj_valid(obj_valid), .obj_ready(obj_ready),
		.tracked_object_number(rec[7:0]),
		.long_distance_deviation_code(rec[15:11]),
		.long_velocity_deviation_code(rec[21:17]),
		.lat_distance_deviation_code(rec[26:22]),
		.lat_velocity_deviation_code(rec[32:28]),
		.lat_accel_deviation_code(rec[38:34]),
		.long_accel_deviation_code(rec[43:39]),
		.orient_deviation_code(rec[49:45]),
		.track_lifecycle_code(rec[52:50]),
		.existence_likelihood_code(rec[55:53]),
		.frame_valid(frame_valid), .frame_ready(frame_ready),
		.frame_id(frame_id), .frame_dlc(frame_dlc),
		.frame_data(frame_data));
	oqf_host_model host_u (.hclk(hclk), .hresetn(hresetn), .stall(stall),
		.slow(slow), .frame_ready(frame_ready));
	always @(posedge hclk) begin
		if (frame_valid === 1'b1 && frame_ready === 1'b1) rx.push_back(frame_data);
	end
	// payload laid out by field position; codes vary with the index
	function automatic [63:0] pk(input integer n);
		integer k;
		int pos[7] = '{11, 17, 22, 28, 34, 39, 45};
		pk = 64'h0;
		pk[7:0] = 8'(n * 37 + 3);
		for (k = 0; k < 7; k++) pk[pos[k] +: 5] = 5'(n * 7 + k * 11);
		pk[50 +: 3] = 3'(n < 40 ? n % 6 : 7);
		pk[53 +: 3] = 3'(n % 8);
	endfunction
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task stop_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task bound(input integer n);
		if (n >= 50) begin
			mismatches++;
			$display("MISMATCH wait expected done seen timeout");
			stop_test;
		end
	endtask
	task ahb(input w, input [7:0] a, input [31:0] wd);
		integer n;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		bound(n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		bound(n);
		d = hrdata;
		chk("hresp", 0, hresp);
	endtask
	task send(input integer n);
		integer c;
		@(posedge hclk);
		obj_valid <= 1'b1;
		rec <= pk(n);
		c = 0;
		do begin @(negedge hclk); c++; end while (obj_ready !== 1'b1 && c < 50);
		bound(c);
		@(posedge hclk);
		obj_valid <= 1'b0;
	endtask
	task cycle;
		@(posedge hclk);
		cycle_start <= 1'b1;
		@(posedge hclk);
		cycle_start <= 1'b0;
	endtask
	task t_off;
		ahb(0, `OQF_REG_CTRL, 0);
		chk("ctrl reset", 0, d);
		ahb(0, 8'h40, 0);
		chk("unmapped", 0, d);
		cycle;
		send(0);
		repeat (3) @(posedge hclk);
		chk("frames while off", 0, rx.size());
		ahb(0, `OQF_REG_DROP, 0);
		chk("drop count", 1, d);
		ahb(0, `OQF_REG_STATUS, 0);
		chk("active while off", 0, d[`OQF_STAT_ACTIVE]);
		chk("empty flag", 1, d[`OQF_STAT_EMPTY]);
	endtask
	task t_fill;
		integer n;
		stall <= 1'b1;
		ahb(1, `OQF_REG_CTRL, 1);
		cycle;
		for (i = 0; i < 32; i++) send(i);
		@(posedge hclk);
		obj_valid <= 1'b1;
		rec <= pk(32);
		@(negedge hclk);
		chk("ready when full", 0, obj_ready);
		chk("frame id", 11'h60C, frame_id);
		chk("frame dlc", 4'h8, frame_dlc);
		ahb(0, `OQF_REG_STATUS, 0);
		chk("full flag", 1, d[`OQF_STAT_FULL]);
		chk("fifo level", 32, d[5:0]);
		chk("active flag", 1, d[`OQF_STAT_ACTIVE]);
		@(posedge hclk);
		obj_valid <= 1'b0;
		stall <= 1'b0;
		slow <= 1'b1;
		n = 0;
		while (rx.size() < 32 && n < 200) begin @(posedge hclk); n++; end
		bound(n / 4);
		for (i = 0; i < 32; i++) chk("payload", pk(i), rx[i]);
		ahb(0, `OQF_REG_SENT, 0);
		chk("sent count", 32, d);
		ahb(0, `OQF_REG_CYCLE, 0);
		chk("cycle count", 2, d);
	endtask
	// undefined lifecycle code is framed as given and counted
	task t_life;
		integer n;
		send(40);
		n = 0;
		while (rx.size() < 33 && n < 50) begin @(posedge hclk); n++; end
		bound(n);
		chk("odd payload", pk(40), rx[32]);
		ahb(0, `OQF_REG_LIFE_ERR, 0);
		chk("lifecycle errors", 1, d);
		ahb(1, `OQF_REG_SENT, 0);
		ahb(0, `OQF_REG_SENT, 0);
		chk("sent cleared", 0, d);
	endtask
	task t_lut;
		int code[3] = '{0, 12, 31};
		int ori[3] = '{5, 332, 'h3FFFF};
		int lin[3] = '{5, 105, 'h3FFFF};
		for (i = 0; i < 3; i++) begin
			ahb(1, `OQF_REG_LUT_SEL, code[i]);
			ahb(0, `OQF_REG_LUT_LIN, 0);
			chk("linear bound", lin[i], d);
			ahb(0, `OQF_REG_LUT_ORIENT, 0);
			chk("orient bound", ori[i], d);
		end
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_off;
		t_fill;
		t_life;
		t_lut;
		stop_test;
	end
endmodule
